/* verilog/dpt_pkg.sv */
// Purpose: Constants for the dual PWM timer block
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes: Offsets are local choices
package dpt_pkg;
  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [7:0] DPT_CTRL_OFS = 8'h00;
  localparam logic [7:0] DPT_HIGH_OFS = 8'h04;
  localparam logic [7:0] DPT_LOW_OFS = 8'h08;
  localparam logic [7:0] DPT_IVL_OFS = 8'h0C;
  localparam logic [7:0] DPT_SFRZ_OFS = 8'h10;
  localparam logic [7:0] DPT_CFRZ_OFS = 8'h14;
  localparam logic [7:0] DPT_TCTRL_OFS = 8'h18;
  localparam logic [7:0] DPT_TPER_OFS = 8'h1C;
  localparam logic [7:0] DPT_DUTY0_OFS = 8'h20;
  localparam logic [7:0] DPT_STAT_OFS = 8'h2C;
  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FAST_BIT = 1;
  localparam int CTRL_DIV10_BIT = 2;
  localparam int CTRL_BURST_BIT = 3;
  localparam int CTRL_FDIV_LSB = 4;
  localparam int TCTRL_EN_BIT = 0;
  localparam int TCTRL_HWP_BIT = 1;
  localparam int TCTRL_SWP_BIT = 2;
  localparam int TCTRL_DIV_LSB = 3;
  localparam int FRZ_BIT = 0;
  // ----------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------
  localparam logic [15:0] DPT_RELOAD_RST = 16'h0000;
  localparam logic [3:0] DPT_DIV10_LAST = 4'h9;
endpackage

/* verilog/dpt_timer.sv */
// Purpose: Dual PWM timer block, 16-bit PWM timer and 14-bit triple PWM
// Assumes: Single clock, slow clock given as a synchronous tick input
// Notes: APB slave, zero wait states
//
// Behaviour
// - Run bit starts timer, loads both counters
// - Period zero toggles phase, alternates shadow reload
// - Primary high in high phase; secondary inverted
// - Burst option: half-rate square in high phase
// - Interval zero waits for low-phase end, interrupts
// - Terminal point reloads counters and shadows
// - Shadows update only at start and terminal point
// - Interrupt also raised at start-up
// - Disabled timer reset except reload registers
// - Reload addresses read live counters
// - Freeze bit stops counting, clear resumes
// - Counters and reloads reset to zero
// - Slow clock default, fast divided; interval /10
// - Triple PWM clock divide 1,2,4,8; enable
// - Triple PWM counters are 14 bits
// - Period counter at zero: outputs high, reload
// - Duty up-counter match drives channel low
// - Duty counter reset while period is zero
// - Radio activity pauses duty, outputs low
// - Software pause bit clear disables pause
`timescale 1ns/1ps
`default_nettype none
module dpt_timer
  import dpt_pkg::*;
#(
  parameter int TW = 16,
  parameter int PW = 14
) (
  input wire logic clk_sys_i, // System clock 250 MHz
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic slow_tick_i, // One-cycle tick of the slow clock
  input wire logic radio_tx_i, // Radio transmit active
  input wire logic radio_rx_i, // Radio receive active
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  output logic primary_pwm_out_o, // Timer PWM
  output logic secondary_pwm_out_o, // Inverted timer PWM
  output logic timer_interrupt_o, // Terminal event pulse
  output logic [2:0] triple_pwm_output_o // Triple PWM outputs
);
  initial begin
    if (TW != 16 || PW != 14) $error("dpt_timer: unsupported widths");
  end
  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [TW-1:0] high_phase_reload_r, low_phase_reload_r, interval_reload_r;
  logic timer_freeze_bit_r;
  logic [5:0] triple_pwm_control_r;
  logic [PW-1:0] period_value_r;
  logic [PW-1:0] duty_r [3];
  logic [TW-1:0] period_counter_r, interval_counter_r;
  logic [PW-1:0] shared_period_counter_r, duty_up_counter_r;
  logic phase_low_r, started_r;
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire run = ctrl_r[CTRL_RUN_BIT];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_r <= 8'h00;
      high_phase_reload_r <= DPT_RELOAD_RST;
      low_phase_reload_r <= DPT_RELOAD_RST;
      interval_reload_r <= DPT_RELOAD_RST;
      triple_pwm_control_r <= 6'h00;
      period_value_r <= '0;
    end else if (wr) begin
      if (hit(paddr_i, DPT_CTRL_OFS)) ctrl_r <= pwdata_i[7:0];
      if (hit(paddr_i, DPT_HIGH_OFS)) high_phase_reload_r <= pwdata_i[TW-1:0];
      if (hit(paddr_i, DPT_LOW_OFS)) low_phase_reload_r <= pwdata_i[TW-1:0];
      if (hit(paddr_i, DPT_IVL_OFS)) interval_reload_r <= pwdata_i[TW-1:0];
      if (hit(paddr_i, DPT_TCTRL_OFS)) triple_pwm_control_r <= pwdata_i[5:0];
      if (hit(paddr_i, DPT_TPER_OFS)) period_value_r <= pwdata_i[PW-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_duty
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          duty_r[g] <= '0;
        end else if (wr && hit(paddr_i, DPT_DUTY0_OFS + 8'(4 * g))) begin
          duty_r[g] <= pwdata_i[PW-1:0];
        end
      end
    end
  endgenerate

  // Freeze set and clear through separate strobe registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      timer_freeze_bit_r <= 1'b0;
    end else if (wr && hit(paddr_i, DPT_SFRZ_OFS) && pwdata_i[FRZ_BIT]) begin
      timer_freeze_bit_r <= 1'b1;
    end else if (wr && hit(paddr_i, DPT_CFRZ_OFS) && pwdata_i[FRZ_BIT]) begin
      timer_freeze_bit_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------
  logic [31:0] rd;
  logic mapped;
  always_comb begin
    rd = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr_i)
      DPT_CTRL_OFS: rd = {24'h000000, ctrl_r};
      DPT_HIGH_OFS, DPT_LOW_OFS: rd = {16'h0000, period_counter_r};
      DPT_IVL_OFS: rd = {16'h0000, interval_counter_r};
      DPT_SFRZ_OFS, DPT_CFRZ_OFS: rd = {31'h0, timer_freeze_bit_r};
      DPT_TCTRL_OFS: rd = {26'h0, triple_pwm_control_r};
      DPT_TPER_OFS: rd = {18'h0, period_value_r};
      DPT_DUTY0_OFS: rd = {18'h0, duty_r[0]};
      8'h24: rd = {18'h0, duty_r[1]};
      8'h28: rd = {18'h0, duty_r[2]};
      DPT_STAT_OFS: rd = {18'h0, duty_up_counter_r};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd : 32'h0000_0000;
    end
  end
  // Note: pready rises in the access cycle, so every transfer is two cycles.

  // ----------------------------------------------------------
  // Timer clock selection
  // ----------------------------------------------------------
  logic [2:0] fdiv_r;
  logic [3:0] div10_r;
  wire [1:0] fsel = ctrl_r[CTRL_FDIV_LSB +: 2];
  logic fast_tick;
  always_comb begin
    case (fsel)
      2'h0: fast_tick = 1'b1;
      2'h1: fast_tick = fdiv_r[0];
      2'h2: fast_tick = &fdiv_r[1:0];
      default: fast_tick = &fdiv_r;
    endcase
  end
  wire tick = !timer_freeze_bit_r &&
              (ctrl_r[CTRL_FAST_BIT] ? fast_tick : slow_tick_i);
  wire ivl_tick = tick && (!ctrl_r[CTRL_DIV10_BIT] || div10_r == DPT_DIV10_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run) begin
      fdiv_r <= 3'h0;
      div10_r <= 4'h0;
    end else begin
      fdiv_r <= fdiv_r + 3'h1;
      if (tick) div10_r <= (div10_r == DPT_DIV10_LAST) ? 4'h0 : div10_r + 4'h1;
    end
  end

  // ----------------------------------------------------------
  // Timer counters
  // ----------------------------------------------------------
  logic [TW-1:0] hi_shadow_r, lo_shadow_r;
  logic burst_r;
  wire term = started_r && tick && phase_low_r &&
              period_counter_r == '0 && interval_counter_r == '0;
  wire start = run && !started_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run) begin
      period_counter_r <= '0;
      interval_counter_r <= '0;
      hi_shadow_r <= '0;
      lo_shadow_r <= '0;
      phase_low_r <= 1'b0;
      started_r <= 1'b0;
    end else if (start || term) begin
      started_r <= 1'b1;
      period_counter_r <= high_phase_reload_r;
      interval_counter_r <= interval_reload_r;
      hi_shadow_r <= high_phase_reload_r;
      lo_shadow_r <= low_phase_reload_r;
      phase_low_r <= 1'b0;
    end else if (tick) begin
      if (period_counter_r == '0) begin
        if (!(phase_low_r && interval_counter_r == '0)) begin
          phase_low_r <= !phase_low_r;
          period_counter_r <= phase_low_r ? hi_shadow_r : lo_shadow_r;
        end
      end else begin
        period_counter_r <= period_counter_r - 1'b1;
      end
      if (ivl_tick && interval_counter_r != '0) begin
        interval_counter_r <= interval_counter_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run || phase_low_r) begin
      burst_r <= 1'b0;
    end else if (tick) begin
      burst_r <= !burst_r;
    end
  end

  wire prim = started_r && !phase_low_r &&
              (!ctrl_r[CTRL_BURST_BIT] || burst_r);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !run) begin
      primary_pwm_out_o <= 1'b0;
      secondary_pwm_out_o <= 1'b1;
      timer_interrupt_o <= 1'b0;
    end else begin
      primary_pwm_out_o <= prim;
      secondary_pwm_out_o <= !prim;
      timer_interrupt_o <= start || term;
    end
  end

  // ----------------------------------------------------------
  // Triple PWM
  // ----------------------------------------------------------
  logic [2:0] tdiv_r;
  wire t_en = triple_pwm_control_r[TCTRL_EN_BIT];
  wire [1:0] tsel = triple_pwm_control_r[TCTRL_DIV_LSB +: 2];
  logic t_tick;
  always_comb begin
    case (tsel)
      2'h0: t_tick = 1'b1;
      2'h1: t_tick = tdiv_r[0];
      2'h2: t_tick = &tdiv_r[1:0];
      default: t_tick = &tdiv_r;
    endcase
  end
  // Pause only when both hardware and software pause bits are set
  wire pause = triple_pwm_control_r[TCTRL_HWP_BIT] && triple_pwm_control_r[TCTRL_SWP_BIT] &&
               (radio_tx_i || radio_rx_i);
  wire per_zero = shared_period_counter_r == '0;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !t_en) begin
      tdiv_r <= 3'h0;
      shared_period_counter_r <= '0;
    end else begin
      tdiv_r <= tdiv_r + 3'h1;
      if (t_tick) begin
        shared_period_counter_r <= per_zero ? period_value_r :
                                   shared_period_counter_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !t_en || period_value_r == '0) begin
      duty_up_counter_r <= '0;
    end else if (t_tick && !pause) begin
      // Radio activity holds the count, a period wrap included
      if (per_zero) duty_up_counter_r <= '0;
      else duty_up_counter_r <= duty_up_counter_r + 1'b1;
    end
  end

  logic [2:0] ch_r;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !t_en) begin
          ch_r[g] <= 1'b0;
        end else if (t_tick && per_zero) begin
          ch_r[g] <= 1'b1;
        end else if (t_tick && duty_up_counter_r == duty_r[g]) begin
          ch_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      triple_pwm_output_o <= 3'h0;
    end else begin
      triple_pwm_output_o <= pause ? 3'h0 : ch_r;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  AST_INV: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    secondary_pwm_out_o == !primary_pwm_out_o) else $error("pwm not inverse");
  AST_START: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    start |=> timer_interrupt_o) else $error("no start irq");
  AST_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    timer_interrupt_o |=> !timer_interrupt_o || $past(term)) else $error("irq long");
  AST_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !run |=> period_counter_r == '0 && interval_counter_r == '0) else $error("off");
  AST_FRZ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    timer_freeze_bit_r && run && started_r |=> $stable(period_counter_r))
    else $error("frozen moved");
  AST_TERM: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    term && run |=> period_counter_r == $past(high_phase_reload_r))
    else $error("no reload");
  AST_PAUSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pause |=> triple_pwm_output_o == 3'h0) else $error("pause out");
  AST_PZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    period_value_r == '0 ##1 period_value_r == '0 |-> duty_up_counter_r == '0)
    else $error("duty run");
endmodule
`default_nettype wire

/* verif/dpt_radio_model.sv */
// Purpose: Far-side model, slow clock tick and radio activity levels
// Assumes: Outputs change only just after a rising clock edge
// Notes: Activity swaps between transmit and receive every 8 cycles
`timescale 1ns/1ps
`default_nettype none
module dpt_radio_model #(
  parameter int TICK_DIV = 8
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic busy_i, // Bench asks for radio activity
  output logic slow_tick_o, // One-cycle slow clock tick
  output logic radio_tx_o, // Transmit active
  output logic radio_rx_o // Receive active
);
  // ----------------------------------------------------------
  // Tick and activity phase
  // ----------------------------------------------------------
  int div_r;
  logic [3:0] ph_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_r <= 0;
      ph_r <= 4'h0;
    end else begin
      div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
      ph_r <= ph_r + 4'h1;
    end
  end
  assign slow_tick_o = (div_r == TICK_DIV - 1);
  // Both indicators take turns so either one alone must pause
  assign radio_tx_o = busy_i & ~ph_r[3];
  assign radio_rx_o = busy_i & ph_r[3];
endmodule
`default_nettype wire

/* verif/dpt_timer_tb.sv */
// Purpose: Self-checking bench for the dual PWM timer block
// Assumes: Zero-wait APB slave, slow tick every 8 clocks
// Notes: Timer figures are measured as run lengths at the outputs
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_tb;
  import dpt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic busy = 1'b0;
  logic [31:0] prdata, q, a;
  logic pready, pslverr, pri, sec, irq, tick, tx, rx, e;
  logic [2:0] tri3;
  logic prev_irq = 1'b0;
  logic prev_pri = 1'b0;
  logic prev_t0 = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0, last_irq = 0, gap = 0, n_irq = 0, irq_long = 0, inv_bad = 0;
  int tog = 0, run = 0, hi_len = 0, lo_len = 0, rise0 = 0, k = 0, t = 0, r = 0;
  int hi[3] = '{0, 0, 0};
  int h[3];
  int rises[4];

  dpt_radio_model dpt_radio_model_i (.clk_i(clk), .rst_n_i(rst_n), .busy_i(busy),
    .slow_tick_o(tick), .radio_tx_o(tx), .radio_rx_o(rx));
  dpt_timer dpt_timer_i (.clk_sys_i(clk), .rst_n_i(rst_n), .slow_tick_i(tick),
    .radio_tx_i(tx), .radio_rx_i(rx), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .primary_pwm_out_o(pri),
    .secondary_pwm_out_o(sec), .timer_interrupt_o(irq), .triple_pwm_output_o(tri3));

  always #2 clk = ~clk;

  // ----------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (rst_n === 1'b1) begin
      cyc++;
      if (sec !== ~pri) inv_bad++;
      if (irq === 1'b1) begin
        n_irq++;
        gap = cyc - last_irq;
        last_irq = cyc;
        if (prev_irq === 1'b1) irq_long++;
      end
      if (pri !== prev_pri) begin
        tog++;
        if (pri === 1'b0) hi_len = run;
        else lo_len = run;
        run = 0;
      end
      run++;
      for (int i = 0; i < 3; i++) hi[i] += (tri3[i] === 1'b1);
      if (tri3[0] === 1'b1 && prev_t0 !== 1'b1) rise0++;
      prev_irq = irq;
      prev_pri = pri;
      prev_t0 = tri3[0];
    end
  end

  // ----------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pri, 32'h0);
    chk(sec, 32'h1);
    rd(DPT_HIGH_OFS, 32'h0);
    rd(DPT_IVL_OFS, 32'h0);
    rd(8'h30, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, DPT_HIGH_OFS, 32'h3);
    apb(1'b1, DPT_LOW_OFS, 32'h5);
    apb(1'b1, DPT_IVL_OFS, 32'h0);
    k = n_irq;
    apb(1'b1, DPT_CTRL_OFS, 32'h3);
    repeat (3) @(posedge clk);
    chk(n_irq - k, 32'h1);
    repeat (40) @(posedge clk);
    chk(hi_len, 32'h4);
    chk(lo_len, 32'h6);
    chk(gap, 32'hA);
    apb(1'b1, DPT_IVL_OFS, 32'h19);
    repeat (80) @(posedge clk);
    chk(gap, 32'h1E);
    k = n_irq;
    for (int i = 0; i < 40 && n_irq == k; i++) @(posedge clk);
    apb(1'b1, DPT_HIGH_OFS, 32'h7);
    repeat (12) @(posedge clk);
    chk(hi_len, 32'h4);
    repeat (45) @(posedge clk);
    chk(hi_len, 32'h8);
    apb(1'b1, DPT_SFRZ_OFS, 32'h1);
    apb(1'b0, DPT_HIGH_OFS, 32'h0000_0000);
    a = q;
    rd(DPT_LOW_OFS, a);
    t = tog;
    repeat (20) @(posedge clk);
    rd(DPT_HIGH_OFS, a);
    chk(tog - t, 32'h0);
    apb(1'b1, DPT_CFRZ_OFS, 32'h1);
    repeat (30) @(posedge clk);
    chk(tog > t, 32'h1);
    t = tog;
    apb(1'b1, DPT_CTRL_OFS, 32'hB);
    repeat (60) @(posedge clk);
    chk(tog - t > 20, 32'h1);
    apb(1'b1, DPT_CTRL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk(pri, 32'h0);
    chk(sec, 32'h1);
    rd(DPT_HIGH_OFS, 32'h0);
    apb(1'b1, DPT_CTRL_OFS, 32'h1);
    repeat (300) @(posedge clk);
    chk(hi_len, 32'h40);
    chk(lo_len, 32'h30);
    apb(1'b1, DPT_CTRL_OFS, 32'h0);
    apb(1'b1, DPT_TPER_OFS, 32'h0);
    apb(1'b1, DPT_TCTRL_OFS, 32'h1);
    repeat (10) @(posedge clk);
    rd(DPT_STAT_OFS, 32'h0);
    apb(1'b1, DPT_TPER_OFS, 32'h14);
    for (int i = 0; i < 3; i++) apb(1'b1, DPT_DUTY0_OFS + 8'(4 * i), 32'(5 + i * 5 + (i / 2) * 5));
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, DPT_TCTRL_OFS, 32'h1 | 32'(d << 3));
      h = hi;
      r = rise0;
      repeat (400) @(posedge clk);
      rises[d] = rise0 - r;
      chk((hi[0] - h[0] > 0) && (hi[0] - h[0] < hi[1] - h[1]), 32'h1);
      chk(hi[1] - h[1] < hi[2] - h[2], 32'h1);
    end
    chk(rises[0] > rises[1] && rises[1] > rises[2] && rises[2] > rises[3], 32'h1);
    apb(1'b1, DPT_TCTRL_OFS, 32'h7);
    busy <= 1'b1;
    repeat (4) @(posedge clk);
    h = hi;
    repeat (50) @(posedge clk);
    chk(hi[0] + hi[1] + hi[2] - h[0] - h[1] - h[2], 32'h0);
    apb(1'b0, DPT_STAT_OFS, 32'h0000_0000);
    a = q;
    repeat (5) @(posedge clk);
    rd(DPT_STAT_OFS, a);
    busy <= 1'b0;
    h = hi;
    repeat (60) @(posedge clk);
    chk(hi[2] > h[2], 32'h1);
    apb(1'b1, DPT_TCTRL_OFS, 32'h3);
    busy <= 1'b1;
    h = hi;
    repeat (60) @(posedge clk);
    chk(hi[2] > h[2], 32'h1);
    busy <= 1'b0;
    chk(inv_bad, 32'h0);
    chk(irq_long, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
